// ### logic/dac_front_end.sv
// Sample capture, serial control port and strap pin handling of the converter front end
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - single rate captures one word on each rising data clock edge.
// - single rate assumes clock edge centred between bus transitions.
// - double rate captures a word on every data clock transition.
// - double rate assumes zero set-up, bus changes with the clock.
// - serial output line drives read data in 4-wire, floats in 3-wire.
// - bidirectional line is input in 4-wire, input and output in 3-wire.
// - with serial port off, serial output line becomes timing alarm output.
// - with serial port off, serial clock line becomes timing update input.
// - with serial port off, rate pin high selects single, low double rate.
// - serial port off pin high disables the serial port, low enables it.
// - chip select is active low; serial activity ignored while it is high.
// - hardware reset pin is active high and restores default state.
// - wire mode bit clear selects 4-wire, set selects 3-wire.
// - sample format bit clear means twos complement, set means unsigned.
// - clock invert bit set inverts data clock before capture.
// - rate bit clear selects double rate, set selects single rate.
module dac_front_end (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        hw_reset_pin,
	input  wire logic                        serial_port_off_pin,
	input  wire logic                        single_rate_select_pin,
	input  wire logic                        chip_select_n,
	input  wire logic                        serial_clock_line,
	input  wire logic                        serial_data_in,
	input  wire logic                        data_clock_input,
	input  wire logic [15:0]                 sample_bus,
	output dac_front_pkg::pin_drive_t        serial_data_drive,
	output dac_front_pkg::pin_drive_t        serial_out_line,
	output dac_front_pkg::core_sample_t      core_sample
);
	import dac_front_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [PIN_N-1:0]  s1_r, s2_r, s3_r, lvl_r;
	logic [PIN_N-1:0]  s1_nxt, s2_nxt, s3_nxt, lvl_nxt;
	logic [WORD_W-1:0] d1_r, d2_r, d3_r, d4_r;
	logic [WORD_W-1:0] d1_nxt, d2_nxt, d3_nxt, d4_nxt;
	logic [PIN_N-1:0]  pins;

	assign pins = {hw_reset_pin, serial_port_off_pin, single_rate_select_pin, chip_select_n,
		serial_clock_line, serial_data_in, data_clock_input};

	always_comb begin
		s1_nxt  = pins;
		s2_nxt  = s1_r;
		s3_nxt  = s2_r;
		// A level moves only once the second and third stages agree
		lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
		d1_nxt  = sample_bus;
		d2_nxt  = d1_r;
		d3_nxt  = d2_r;
		d4_nxt  = d3_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r  <= PIN_RESET;
			s2_r  <= PIN_RESET;
			s3_r  <= PIN_RESET;
			lvl_r <= PIN_RESET;
			d1_r  <= '0;
			d2_r  <= '0;
			d3_r  <= '0;
			d4_r  <= '0;
		end else begin
			s1_r  <= s1_nxt;
			s2_r  <= s2_nxt;
			s3_r  <= s3_nxt;
			lvl_r <= lvl_nxt;
			d1_r  <= d1_nxt;
			d2_r  <= d2_nxt;
			d3_r  <= d3_nxt;
			d4_r  <= d4_nxt;
		end
	end

	// ==========================================================
	// Mode decode
	logic       rst;
	logic [7:0] ctrl0_r, ctrl2_r;
	logic       alarm_r;
	logic       port_off, sdr_mode, three_wire, spi_active;
	logic       dclk_edge, dclk_rise, sclk_rise, sclk_fall;

	assign rst        = !aresetn || lvl_r[PIN_HWRST];
	assign port_off   = lvl_r[PIN_OFF];
	assign sdr_mode   = port_off ? lvl_r[PIN_RATE] : ctrl2_r[RATE_BIT];
	assign three_wire = ctrl0_r[WIRE_MODE_BIT];
	assign spi_active = !port_off && !lvl_r[PIN_CSN];
	assign dclk_edge  = lvl_nxt[PIN_DCLK] ^ lvl_r[PIN_DCLK];
	assign dclk_rise  = dclk_edge && (lvl_nxt[PIN_DCLK] ^ ctrl2_r[INVERT_BIT]);
	assign sclk_rise  = lvl_nxt[PIN_SCLK] && !lvl_r[PIN_SCLK];
	assign sclk_fall  = !lvl_nxt[PIN_SCLK] && lvl_r[PIN_SCLK];

	// ==========================================================
	// Sample capture
	core_sample_t core_r, core_nxt;
	logic [GAP_W-1:0] gap_r, gap_nxt;
	logic             take;

	always_comb begin
		// Word from before the detected edge: zero set-up still lands safely
		take = sdr_mode ? dclk_rise : dclk_edge;
		core_nxt.valid = take;
		core_nxt.word  = core_r.word;
		if (take) begin
			core_nxt.word = ctrl2_r[FORMAT_BIT] ? (d4_r ^ SIGN_FLIP) : d4_r;
		end
		gap_nxt = (gap_r == GAP_MAX) ? gap_r : gap_r + 4'h1;
		if (dclk_edge) begin
			gap_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			core_r <= '0;
			gap_r  <= GAP_MAX;
		end else begin
			core_r <= core_nxt;
			gap_r  <= gap_nxt;
		end
	end

	assign core_sample = core_r;

	// ==========================================================
	// Serial control port
	spi_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shin_r, shin_nxt, shout_r, shout_nxt, shin_new;
	logic [6:0] spi_addr_r, spi_addr_nxt;
	logic       spi_wr_r, spi_wr_nxt;
	logic [7:0] spi_wdata_r, spi_wdata_nxt;
	logic       obit_r, obit_nxt;
	pin_drive_t sdio_r, sdio_nxt, sdo_r, sdo_nxt;
	logic       reading;

	function automatic logic [31:0] reg_read(input logic [6:0] idx);
		logic [31:0] v;
		v = '0;
		unique case (idx)
			IDX_CTRL0:  v = {24'h0, ctrl0_r};
			IDX_CTRL2:  v = {24'h0, ctrl2_r[7:1], alarm_r};
			IDX_STATUS: v = {30'h0, sdr_mode, port_off};
			default:    v = '0;
		endcase
		return v;
	endfunction

	function automatic logic is_mapped(input logic [6:0] idx);
		return (idx == IDX_CTRL0) || (idx == IDX_CTRL2) || (idx == IDX_STATUS);
	endfunction

	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		shin_nxt      = shin_r;
		shout_nxt     = shout_r;
		spi_addr_nxt  = spi_addr_r;
		spi_wr_nxt    = 1'b0;
		spi_wdata_nxt = spi_wdata_r;
		obit_nxt      = obit_r;
		shin_new      = {shin_r[6:0], lvl_r[PIN_SDIO]};
		if (!spi_active) begin
			state_nxt = SPI_INSTR;
			cnt_nxt   = '0;
		end else begin
			if (sclk_rise) begin
				shin_nxt = shin_new;
				cnt_nxt  = cnt_r + 4'h1;
				unique case (state_r)
					SPI_INSTR: begin
						if (cnt_r == SPI_INSTR_LAST) begin
							spi_addr_nxt = shin_new[6:0];
							state_nxt    = shin_new[SPI_RW_BIT] ? SPI_READ : SPI_WRITE;
							shout_nxt    = 8'(reg_read(shin_new[6:0]));
						end
					end
					SPI_WRITE: begin
						if (cnt_r == SPI_FRAME_LAST) begin
							spi_wr_nxt    = 1'b1;
							spi_wdata_nxt = shin_new;
							state_nxt     = SPI_INSTR;
						end
					end
					SPI_READ: begin
						if (cnt_r == SPI_FRAME_LAST) begin
							state_nxt = SPI_INSTR;
						end
					end
				endcase
			end
			if (sclk_fall && state_r == SPI_READ) begin
				obit_nxt  = shout_r[7];
				shout_nxt = {shout_r[6:0], 1'b0};
			end
		end
		reading = spi_active && (state_nxt == SPI_READ);
		// Serial output line: alarm when port off, else read data in 4-wire only
		if (port_off) begin
			sdo_nxt = '{dout: alarm_r, oe_n: 1'b0};
		end else if (three_wire) begin
			sdo_nxt = '{dout: 1'b0, oe_n: 1'b1};
		end else begin
			sdo_nxt = '{dout: obit_nxt, oe_n: !reading};
		end
		// Bidirectional line only turns round in 3-wire read phase
		sdio_nxt = '{dout: obit_nxt, oe_n: !(reading && three_wire && !port_off)};
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			state_r     <= SPI_INSTR;
			cnt_r       <= '0;
			shin_r      <= '0;
			shout_r     <= '0;
			spi_addr_r  <= '0;
			spi_wr_r    <= 1'b0;
			spi_wdata_r <= '0;
			obit_r      <= 1'b0;
			sdo_r       <= '{dout: 1'b0, oe_n: 1'b1};
			sdio_r      <= '{dout: 1'b0, oe_n: 1'b1};
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			shin_r      <= shin_nxt;
			shout_r     <= shout_nxt;
			spi_addr_r  <= spi_addr_nxt;
			spi_wr_r    <= spi_wr_nxt;
			spi_wdata_r <= spi_wdata_nxt;
			obit_r      <= obit_nxt;
			sdo_r       <= sdo_nxt;
			sdio_r      <= sdio_nxt;
		end
	end

	assign serial_out_line   = sdo_r;
	assign serial_data_drive = sdio_r;

	// ==========================================================
	// Register bus slave and control registers
	logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic        aw_hold_r, w_hold_r, aw_hold_nxt, w_hold_nxt;
	logic [6:0]  aw_idx_r, aw_idx_nxt, ar_idx;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0]  ctrl0_nxt, ctrl2_nxt;
	logic        alarm_nxt, commit, upd_pulse;

	always_comb begin
		awready_nxt = s_axi_awvalid && !awready_r && !aw_hold_r && !bvalid_r;
		wready_nxt  = s_axi_wvalid && !wready_r && !w_hold_r && !bvalid_r;
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		aw_idx_nxt  = aw_idx_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		if (s_axi_awvalid && awready_r) begin
			aw_hold_nxt = 1'b1;
			aw_idx_nxt  = {1'b0, s_axi_awaddr[ADDR_W-1:IDX_LSB]};
		end
		if (s_axi_wvalid && wready_r) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		commit     = aw_hold_r && w_hold_r && !bvalid_r;
		bvalid_nxt = bvalid_r && !s_axi_bready;
		bresp_nxt  = bresp_r;
		if (commit) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
		end
		ar_idx      = {1'b0, s_axi_araddr[ADDR_W-1:IDX_LSB]};
		arready_nxt = s_axi_arvalid && !arready_r && !rvalid_r;
		rvalid_nxt  = rvalid_r && !s_axi_rready;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = reg_read(ar_idx);
			rresp_nxt  = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		// Bus write wins a same-cycle clash; the serial write is then lost
		ctrl0_nxt = ctrl0_r;
		ctrl2_nxt = ctrl2_r;
		if (commit && wstrb_r[0]) begin
			if (aw_idx_r == IDX_CTRL0) begin
				ctrl0_nxt = (ctrl0_r & ~CTRL0_WMASK) | (wdata_r[7:0] & CTRL0_WMASK);
			end
			if (aw_idx_r == IDX_CTRL2) begin
				ctrl2_nxt = (ctrl2_r & ~CTRL2_WMASK) | (wdata_r[7:0] & CTRL2_WMASK);
			end
		end else if (spi_wr_r) begin
			if (spi_addr_r == IDX_CTRL0) begin
				ctrl0_nxt = (ctrl0_r & ~CTRL0_WMASK) | (spi_wdata_r & CTRL0_WMASK);
			end
			if (spi_addr_r == IDX_CTRL2) begin
				ctrl2_nxt = (ctrl2_r & ~CTRL2_WMASK) | (spi_wdata_r & CTRL2_WMASK);
			end
		end
		// Edges at most the shortest half period apart raise the alarm; set beats clear
		upd_pulse = port_off && sclk_rise;
		alarm_nxt = (dclk_edge && gap_r < GAP_LIMIT) || (alarm_r && !upd_pulse);
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_idx_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
			bresp_r   <= RESP_OKAY;
			rdata_r   <= '0;
			rresp_r   <= RESP_OKAY;
			ctrl0_r   <= CTRL0_RESET;
			ctrl2_r   <= CTRL2_RESET;
			alarm_r   <= 1'b0;
		end else begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r  <= w_hold_nxt;
			aw_idx_r  <= aw_idx_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bresp_r   <= bresp_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			ctrl0_r   <= ctrl0_nxt;
			ctrl2_r   <= ctrl2_nxt;
			alarm_r   <= alarm_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
endmodule

// ### logic/dac_front_pkg.sv
// Shared constants, register layout and carrier types of the converter front end
package dac_front_pkg;
	// ==========================================================
	// Register map (index, byte address is four times the index)
	localparam logic [6:0] IDX_CTRL0    = 7'h00;
	localparam logic [6:0] IDX_CTRL2    = 7'h02;
	localparam logic [6:0] IDX_STATUS   = 7'h03;
	localparam int         ADDR_W       = 8;
	localparam int         IDX_LSB      = 2;
	localparam logic [7:0] CTRL0_RESET  = 8'h00;
	localparam logic [7:0] CTRL2_RESET  = 8'h00;
	localparam logic [7:0] CTRL0_WMASK  = 8'hF9;
	localparam logic [7:0] CTRL2_WMASK  = 8'hFE;
	localparam int         WIRE_MODE_BIT = 7;
	localparam int         FORMAT_BIT   = 7;
	localparam int         RATE_BIT     = 6;
	localparam int         INVERT_BIT   = 5;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	// ==========================================================
	// Pin sampling vector layout
	localparam int         PIN_N        = 7;
	localparam int         PIN_DCLK     = 0;
	localparam int         PIN_SDIO     = 1;
	localparam int         PIN_SCLK     = 2;
	localparam int         PIN_CSN      = 3;
	localparam int         PIN_RATE     = 4;
	localparam int         PIN_OFF      = 5;
	localparam int         PIN_HWRST    = 6;
	localparam logic [6:0] PIN_RESET    = 7'h08;
	// ==========================================================
	// Sample path and serial framing
	localparam int          WORD_W      = 16;
	localparam logic [15:0] SIGN_FLIP   = 16'h8000;
	localparam logic [3:0]  SPI_INSTR_LAST = 4'h7;
	localparam logic [3:0]  SPI_FRAME_LAST = 4'hF;
	localparam int          SPI_RW_BIT  = 7;
	// ==========================================================
	// Timing: shortest half period of the data clock before an alarm
	localparam int         CLK_FREQ_MHZ = 40;
	localparam int         MIN_HALF_NS  = 75;
	localparam int         MIN_HALF_CYC = (MIN_HALF_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int         GAP_W        = 4;
	localparam logic [3:0] GAP_MAX      = 4'hF;
	localparam logic [3:0] GAP_LIMIT    = 4'(MIN_HALF_CYC);
	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic dout;
		logic oe_n;
	} pin_drive_t;
	typedef struct packed {
		logic [15:0] word;
		logic        valid;
	} core_sample_t;
	typedef enum logic [1:0] {SPI_INSTR, SPI_WRITE, SPI_READ} spi_state_t;
endpackage

// ### verification/dac_front_end_properties.sv
// Port-level checker of the converter front end
`timescale 1ns/1ps
// ==========================================================
// Checker
module dac_front_end_checker (
	input logic                       aclk,
	input logic                       aresetn,
	input logic                       s_axi_awready,
	input logic [1:0]                 s_axi_bresp,
	input logic                       s_axi_bvalid,
	input logic                       s_axi_bready,
	input logic                       s_axi_arvalid,
	input logic                       s_axi_arready,
	input logic [31:0]                s_axi_rdata,
	input logic                       s_axi_rvalid,
	input logic                       s_axi_rready,
	input logic                       hw_reset_pin,
	input logic                       serial_port_off_pin,
	input logic                       chip_select_n,
	input dac_front_pkg::pin_drive_t  serial_data_drive,
	input dac_front_pkg::pin_drive_t  serial_out_line,
	input dac_front_pkg::core_sample_t core_sample
);
	// Pins pass synchronisers, so level checks wait for a settled run
	logic [4:0]      c;
	logic [4:0][3:0] q_r;
	logic [4:0][3:0] q_nxt;
	assign c = {chip_select_n, !serial_port_off_pin, serial_port_off_pin, hw_reset_pin,
		!hw_reset_pin};
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			q_nxt[i] = c[i] ? (q_r[i] == 4'hF ? 4'hF : q_r[i] + 4'h1) : 4'h0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) q_r <= '0;
		else q_r <= q_nxt;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// Properties
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_rans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_awpulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_awpulse: assert property (p_awpulse) else $error("awready longer than a cycle");
	property p_vpulse;
		core_sample.valid |=> !core_sample.valid;
	endproperty
	a_vpulse: assert property (p_vpulse) else $error("sample repeated");
	property p_onedrv;
		!serial_data_drive.oe_n |-> serial_out_line.oe_n;
	endproperty
	a_onedrv: assert property (p_onedrv) else $error("both serial lines driven");
	property p_csidle;
		q_r[4] > 4'h8 && q_r[3] > 4'h8 |-> serial_data_drive.oe_n && serial_out_line.oe_n;
	endproperty
	a_csidle: assert property (p_csidle) else $error("drive without chip select");
	property p_off;
		q_r[2] > 4'h8 && q_r[0] > 4'h8 |-> !serial_out_line.oe_n && serial_data_drive.oe_n;
	endproperty
	a_off: assert property (p_off) else $error("port off pin roles wrong");
	property p_hw;
		q_r[1] > 4'h8 |-> core_sample == '0 && serial_out_line.oe_n && !s_axi_bvalid;
	endproperty
	a_hw: assert property (p_hw) else $error("hardware reset not applied");
	c_word: cover property (core_sample.valid);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_alarm: cover property (!serial_out_line.oe_n && serial_port_off_pin);
endmodule

bind dac_front_end dac_front_end_checker chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.hw_reset_pin(hw_reset_pin), .serial_port_off_pin(serial_port_off_pin),
	.chip_select_n(chip_select_n), .serial_data_drive(serial_data_drive),
	.serial_out_line(serial_out_line), .core_sample(core_sample));

// ### verification/data_pump.sv
// Data pump model driving the forwarded data clock and sample bus
`timescale 1ns/1ps
// ==========================================================
// Data pump
module data_pump (
	input  logic        aclk,
	input  logic        start,
	input  logic        sdr,
	input  logic        lead,
	input  logic [3:0]  half,
	input  logic [15:0] base,
	output logic        data_clock_input,
	output logic [15:0] sample_bus,
	output logic        busy
);
	// Clock stands still between bursts
	initial begin
		data_clock_input = 1'b0;
		sample_bus = 16'h0000;
		busy = 1'b0;
		forever begin
			@(posedge aclk);
			if (start) begin
				busy <= 1'b1;
				for (int i = 0; i < 4; i++) begin
					sample_bus <= base + 16'(i);
					if (sdr && lead) data_clock_input <= ~data_clock_input;
					repeat (half) @(posedge aclk);
					data_clock_input <= ~data_clock_input;
					repeat (half) @(posedge aclk);
					if (sdr && !lead) data_clock_input <= ~data_clock_input;
				end
				// Released bus shows the inverse so stale data cannot pass
				sample_bus <= ~sample_bus;
				busy <= 1'b0;
			end
		end
	end
endmodule

// ### verification/tb_dac_front_end.sv
// Self-checking bench of the converter front end
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb_dac_front_end;
	import dac_front_pkg::*;
	logic         aclk, aresetn, hw_reset_pin, serial_port_off_pin, single_rate_select_pin;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb, p_half;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic         chip_select_n, serial_clock_line, serial_data_in, data_clock_input;
	logic         m_oe, m_dat, p_start, p_sdr, p_lead, p_busy;
	logic [15:0]  sample_bus, p_base;
	logic [15:0]  got[$];
	pin_drive_t   serial_data_drive, serial_out_line;
	core_sample_t core_sample;
	int           error_cnt, num_checks;
	event         hang;
	// Wire level of the shared line, floating shown as a toggling pattern
	assign serial_data_in = !serial_data_drive.oe_n ? serial_data_drive.dout : (m_oe ? m_dat : aclk);
	dac_front_end dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .hw_reset_pin(hw_reset_pin),
		.serial_port_off_pin(serial_port_off_pin), .single_rate_select_pin(single_rate_select_pin),
		.chip_select_n(chip_select_n), .serial_clock_line(serial_clock_line),
		.serial_data_in(serial_data_in), .data_clock_input(data_clock_input),
		.sample_bus(sample_bus), .serial_data_drive(serial_data_drive),
		.serial_out_line(serial_out_line), .core_sample(core_sample));
	data_pump pump (.aclk(aclk), .start(p_start), .sdr(p_sdr), .lead(p_lead), .half(p_half),
		.base(p_base), .data_clock_input(data_clock_input), .sample_bus(sample_bus), .busy(p_busy));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) if (core_sample.valid === 1'b1) got.push_back(core_sample.word);
	initial begin
		@(hang);
		// A run that hangs must never reach the pass verdict
		error_cnt++;
		final_report();
	end
	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		check("bresp", 32'(s_axi_bresp), 32'(er));
		if (n >= 100) -> hang;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, {24'h000000, d});
		check("rresp", 32'(s_axi_rresp), 32'(er));
		if (n >= 100) -> hang;
	endtask
	task automatic burst(input logic s, input logic l, input logic [3:0] h, input logic [15:0] b,
		input logic [15:0] fl, input logic ck);
		int n;
		n = 0;
		// Settle first so a capture caused by a mode change is not counted
		repeat (10) @(posedge aclk);
		got.delete();
		p_sdr <= s;
		p_lead <= l;
		p_half <= h;
		p_base <= b;
		p_start <= 1'b1;
		@(posedge aclk);
		p_start <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (p_busy === 1'b1 && n < 200);
		if (n >= 200) -> hang;
		repeat (10) @(posedge aclk);
		if (ck) begin
			check("count", 32'(got.size()), 32'h4);
			foreach (got[i]) check("word", 32'(got[i]), 32'(16'((b + 16'(i)) ^ fl)));
		end
	endtask
	task automatic spi(input logic [15:0] f, input logic w3, input logic [7:0] exp);
		logic [7:0] rd;
		rd = 8'h00;
		@(posedge aclk);
		chip_select_n <= 1'b0;
		m_oe <= 1'b1;
		for (int i = 15; i >= 0; i--) begin
			if (i == 7 && f[15]) m_oe <= 1'b0;
			m_dat <= f[i];
			repeat (6) @(posedge aclk);
			rd = {rd[6:0], w3 ? serial_data_in : serial_out_line.dout};
			// Drive ends at the last rising edge, so look before it
			if (i == 0 && f[15]) begin
				check("out_oe_n", 32'(serial_out_line.oe_n), 32'(w3));
				check("bidir_oe_n", 32'(serial_data_drive.oe_n), 32'(!w3));
			end
			serial_clock_line <= 1'b1;
			repeat (6) @(posedge aclk);
			serial_clock_line <= 1'b0;
		end
		if (f[15]) begin
			check("serial_rd", 32'(rd), 32'(exp));
		end
		@(posedge aclk);
		chip_select_n <= 1'b1;
		m_oe <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	// ==========================================================
	// Sequence
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		{hw_reset_pin, serial_port_off_pin, single_rate_select_pin, serial_clock_line} = '0;
		{p_start, p_sdr, p_lead, m_oe, m_dat} = '0;
		chip_select_n = 1'b1;
		p_half = 4'h2;
		p_base = 16'h0000;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_rd(8'h00, 8'h00, RESP_OKAY);
		axi_rd(8'h08, 8'h00, RESP_OKAY);
		axi_rd(8'h0C, 8'h00, RESP_OKAY);
		axi_rd(8'h04, 8'h00, RESP_SLVERR);
		axi_wr(8'h04, 8'h5A, RESP_SLVERR);
		burst(1'b0, 1'b0, 4'h2, 16'h1230, 16'h0000, 1'b1);
		axi_wr(8'h08, 8'h40, RESP_OKAY);
		burst(1'b1, 1'b0, 4'h4, 16'h7FFE, 16'h0000, 1'b1);
		axi_wr(8'h08, 8'hC0, RESP_OKAY);
		burst(1'b1, 1'b0, 4'h4, 16'hFFFE, SIGN_FLIP, 1'b1);
		axi_wr(8'h08, 8'h60, RESP_OKAY);
		burst(1'b1, 1'b1, 4'h4, 16'h0100, 16'h0000, 1'b1);
		spi(16'h8200, 1'b0, 8'h60);
		spi(16'h0281, 1'b0, 8'h00);
		axi_rd(8'h08, 8'h80, RESP_OKAY);
		axi_wr(8'h00, 8'hFF, RESP_OKAY);
		axi_rd(8'h00, 8'hF9, RESP_OKAY);
		spi(16'h8000, 1'b1, 8'hF9);
		hw_reset_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		hw_reset_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		axi_rd(8'h00, 8'h00, RESP_OKAY);
		axi_rd(8'h08, 8'h00, RESP_OKAY);
		serial_port_off_pin <= 1'b1;
		single_rate_select_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		axi_rd(8'h0C, 8'h03, RESP_OKAY);
		check("alarm_oe_n", 32'(serial_out_line.oe_n), 32'h0);
		burst(1'b1, 1'b0, 4'h4, 16'h4440, 16'h0000, 1'b1);
		burst(1'b1, 1'b0, 4'h2, 16'h0000, 16'h0000, 1'b0);
		check("alarm_set", 32'(serial_out_line.dout), 32'h1);
		axi_rd(8'h08, 8'h01, RESP_OKAY);
		serial_clock_line <= 1'b1;
		repeat (8) @(posedge aclk);
		serial_clock_line <= 1'b0;
		repeat (8) @(posedge aclk);
		check("alarm_clr", 32'(serial_out_line.dout), 32'h0);
		single_rate_select_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		axi_rd(8'h0C, 8'h01, RESP_OKAY);
		burst(1'b0, 1'b0, 4'h2, 16'h0A00, 16'h0000, 1'b1);
		final_report();
	end
endmodule
